// ==== verilog/tpwm_pkg.sv ====
// Constants shared by the ten-bit pulse-width modulator and its time base.
package tpwm_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [4:0] CTRL_OFS    = 5'h00;
	localparam logic [4:0] DUTY_HI_OFS = 5'h04;
	localparam logic [4:0] DUTY_LO_OFS = 5'h08;
	localparam logic [4:0] PERIOD_OFS  = 5'h0c;
	localparam logic [4:0] TCTRL_OFS   = 5'h10;
	localparam logic [4:0] COUNT_OFS   = 5'h14;
	localparam logic [4:0] FLAG_OFS    = 5'h18;
	localparam logic [4:0] PINDIR_OFS  = 5'h1c;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int EN_BIT   = 7;
	localparam int OUT_BIT  = 5;
	localparam int POL_BIT  = 4;
	localparam int DCL_LSB  = 6;
	localparam int TON_BIT  = 7;
	localparam int PS_LSB   = 4;
	localparam int FLAG_BIT = 1;
	localparam int DIR_BIT  = 0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [9:0] DUTY_RST   = 10'h000;
	localparam logic [7:0] PERIOD_RST = 8'hff;
	localparam logic [2:0] PS_RST     = 3'h0;
	localparam logic       DIR_RST    = 1'b1;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int         FINE_W     = 9;
	localparam logic [9:0] TOSC_TICK  = 10'h004;

endpackage : tpwm_pkg

// ==== verilog/tpwm_tb_if.sv ====
// Link between the modulator control logic and its timer time base.
`timescale 1ns/1ps
`default_nettype none
interface tpwm_tb_if;
	logic       run;
	logic [2:0] ps_sel;
	logic [7:0] period;
	logic [7:0] count;
	logic [9:0] base;
	logic       roll;

	modport tb  (input run, ps_sel, period, output count, base, roll);
	modport ctl (output run, ps_sel, period, input count, base, roll);
endinterface : tpwm_tb_if
`default_nettype wire

// ==== verilog/tpwm_timebase.sv ====
// Prescaled eight-bit period timer extended to a ten-bit time base.
`timescale 1ns/1ps
`default_nettype none
module tpwm_timebase
	import tpwm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	tpwm_tb_if.tb     tb
);

	typedef struct packed {
		logic [FINE_W-1:0] fine;
		logic [7:0]        count;
		logic              roll;
	} tpwm_tb_s;

	tpwm_tb_s          st_ff;
	tpwm_tb_s          nxt_st;
	logic [FINE_W-1:0] last;
	logic [FINE_W-1:0] sub;

	// ------------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------------
	always_comb begin
		last = FINE_W'((TOSC_TICK << tb.ps_sel) - 10'h001);
		sub = st_ff.fine >> tb.ps_sel;
		nxt_st = st_ff;
		nxt_st.roll = 1'b0;
		if (tb.run) begin
			if (st_ff.fine >= last) begin
				nxt_st.fine = '0;
				if (st_ff.count == tb.period) begin
					nxt_st.count = 8'h00;
					nxt_st.roll = 1'b1;
				end else begin
					nxt_st.count = st_ff.count + 8'h01;
				end
			end else begin
				nxt_st.fine = st_ff.fine + 9'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tb.count = st_ff.count;
	assign tb.base  = {st_ff.count, sub[1:0]};
	assign tb.roll  = st_ff.roll;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_count_clear: assert property (tb.run && st_ff.fine == last &&
		st_ff.count == tb.period |=> st_ff.count == 8'h00 && st_ff.roll)
		else $error("timer did not clear after period match");
	a_count_hold: assert property (!tb.run |=> $stable(st_ff.count) &&
		$stable(st_ff.fine) && !st_ff.roll)
		else $error("timer moved while stopped");
	a_fine_wrap: assert property (tb.run && st_ff.fine == last &&
		$stable(tb.ps_sel) |=> st_ff.fine == '0)
		else $error("prescaler did not wrap at its ratio");

endmodule : tpwm_timebase
`default_nettype wire

// ==== verilog/tpwm_top.sv ====
// Ten-bit pulse-width modulator with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module tpwm_top
	import tpwm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        sleep_req,
	output logic             pwm_pin_out,
	output logic             pwm_pin_oe_n
);

	typedef struct packed {
		logic        sl_meta;
		logic        sl_sync;
		logic        en;
		logic        pol;
		logic [7:0]  duty_hi;
		logic [1:0]  duty_lo;
		logic [9:0]  duty_act;
		logic [7:0]  period;
		logic        ton;
		logic [2:0]  ps;
		logic        flag;
		logic        dir;
		logic        active;
		logic        pin;
		logic        wait_r;
		logic [31:0] rdata;
	} tpwm_st_s;

	tpwm_st_s    st_ff;
	tpwm_st_s    nxt_st;
	tpwm_tb_if   tbi ();
	logic [9:0]  duty;
	logic [31:0] rd_val;
	logic        wr_take;
	logic        rd_take;
	logic        sleeping;

	// ------------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------------
	tpwm_timebase u_timebase (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tb      (tbi.tb)
	);

	assign tbi.run    = st_ff.ton && !sleeping;
	assign tbi.ps_sel = st_ff.ps;
	assign tbi.period = st_ff.period;

	// ------------------------------------------------------------------
	// Register read view
	// ------------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0000_0000;
		case (avs_address)
			CTRL_OFS: begin
				rd_val[EN_BIT] = st_ff.en;
				rd_val[OUT_BIT] = st_ff.pin;
				rd_val[POL_BIT] = st_ff.pol;
			end
			DUTY_HI_OFS: begin
				rd_val[7:0] = st_ff.duty_hi;
			end
			DUTY_LO_OFS: begin
				rd_val[DCL_LSB+:2] = st_ff.duty_lo;
			end
			PERIOD_OFS: begin
				rd_val[7:0] = st_ff.period;
			end
			TCTRL_OFS: begin
				rd_val[TON_BIT] = st_ff.ton;
				rd_val[PS_LSB+:3] = st_ff.ps;
			end
			COUNT_OFS: begin
				rd_val[7:0] = tbi.count;
			end
			FLAG_OFS: begin
				rd_val[FLAG_BIT] = st_ff.flag;
			end
			PINDIR_OFS: begin
				rd_val[DIR_BIT] = st_ff.dir;
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		sleeping = st_ff.sl_sync;
		duty = {st_ff.duty_hi, st_ff.duty_lo};
		rd_take = avs_read && st_ff.wait_r;
		wr_take = avs_write && !st_ff.wait_r;
		nxt_st.sl_meta = sleep_req;
		nxt_st.sl_sync = st_ff.sl_meta;

		if (avs_read || avs_write) begin
			nxt_st.wait_r = !st_ff.wait_r;
		end else begin
			nxt_st.wait_r = 1'b1;
		end
		if (rd_take) begin
			nxt_st.rdata = rd_val;
		end

		if (wr_take && avs_byteenable[0]) begin
			case (avs_address)
				CTRL_OFS: begin
					nxt_st.en = avs_writedata[EN_BIT];
					nxt_st.pol = avs_writedata[POL_BIT];
				end
				DUTY_HI_OFS: begin
					nxt_st.duty_hi = avs_writedata[7:0];
				end
				DUTY_LO_OFS: begin
					nxt_st.duty_lo = avs_writedata[DCL_LSB+:2];
				end
				PERIOD_OFS: begin
					nxt_st.period = avs_writedata[7:0];
				end
				TCTRL_OFS: begin
					nxt_st.ton = avs_writedata[TON_BIT];
					nxt_st.ps = avs_writedata[PS_LSB+:3];
				end
				FLAG_OFS: begin
					if (avs_writedata[FLAG_BIT]) begin
						nxt_st.flag = 1'b0;
					end
				end
				PINDIR_OFS: begin
					nxt_st.dir = avs_writedata[DIR_BIT];
				end
				default: begin
					nxt_st.flag = nxt_st.flag;
				end
			endcase
		end

		if (tbi.roll) begin
			nxt_st.flag = 1'b1;
			nxt_st.duty_act = duty;
			nxt_st.active = (duty != 10'h000);
		end else if (!sleeping && tbi.base == st_ff.duty_act) begin
			nxt_st.active = 1'b0;
		end

		if (st_ff.en) begin
			nxt_st.pin = st_ff.active ^ st_ff.pol;
		end else begin
			nxt_st.pin = st_ff.pol;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.duty_hi <= DUTY_RST[9:2];
			st_ff.duty_lo <= DUTY_RST[1:0];
			st_ff.duty_act <= DUTY_RST;
			st_ff.period <= PERIOD_RST;
			st_ff.ps <= PS_RST;
			st_ff.dir <= DIR_RST;
			st_ff.wait_r <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata    = st_ff.rdata;
	assign avs_waitrequest = st_ff.wait_r;
	assign pwm_pin_out     = st_ff.pin;
	assign pwm_pin_oe_n    = st_ff.dir;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_roll_nonzero;
		tbi.roll && duty != 10'h000;
	endsequence

	sequence s_roll_zero;
		tbi.roll && duty == 10'h000;
	endsequence

	sequence s_bus_start;
		(avs_read || avs_write) && st_ff.wait_r;
	endsequence

	a_roll_set: assert property (s_roll_nonzero |=> st_ff.active)
		else $error("output not set at rollover");
	a_roll_zero: assert property (s_roll_zero |=> !st_ff.active)
		else $error("zero duty set the output");
	a_roll_latch: assert property (tbi.roll |=>
		st_ff.duty_act == $past(duty))
		else $error("duty not latched at rollover");
	a_duty_hold: assert property (!tbi.roll |=> $stable(st_ff.duty_act))
		else $error("active duty changed between rollovers");
	a_match_clear: assert property (st_ff.active && !tbi.roll &&
		!sleeping && tbi.base == st_ff.duty_act |=> !st_ff.active)
		else $error("output not cleared at duty match");
	a_sleep_hold: assert property (sleeping && !tbi.roll |=>
		$stable(st_ff.active) && $stable(tbi.count))
		else $error("state moved during sleep");
	a_idle_level: assert property (!st_ff.en ##1 $stable(st_ff.pol) |->
		pwm_pin_out == st_ff.pol)
		else $error("disabled output not at idle level");
	a_pin_follow: assert property (st_ff.en |=>
		pwm_pin_out == ($past(st_ff.active) ^ $past(st_ff.pol)))
		else $error("enabled output does not follow modulator");
	a_status_read: assert property (avs_read && st_ff.wait_r &&
		avs_address == CTRL_OFS |=> avs_readdata[OUT_BIT] == $past(st_ff.pin))
		else $error("status bit does not show output level");
	a_bus_answer: assert property (s_bus_start |=> !avs_waitrequest ##1
		avs_waitrequest)
		else $error("bus answer not one wait cycle");

	// ------------------------------------------------------------------
	// Register, sleep and active-hold checks
	// ------------------------------------------------------------------
	sequence s_flag_clear;
		wr_take && avs_byteenable[0] && avs_address == FLAG_OFS &&
			avs_writedata[FLAG_BIT] && !tbi.roll;
	endsequence

	sequence s_dir_write;
		wr_take && avs_byteenable[0] && avs_address == PINDIR_OFS;
	endsequence

	sequence s_duty_hi_write;
		wr_take && avs_byteenable[0] && avs_address == DUTY_HI_OFS;
	endsequence

	sequence s_duty_lo_write;
		wr_take && avs_byteenable[0] && avs_address == DUTY_LO_OFS;
	endsequence

	sequence s_sleep_pin;
		sleeping && !tbi.roll ##1 sleeping && !tbi.roll &&
			$stable(st_ff.en) && $stable(st_ff.pol);
	endsequence

	a_flag_set: assert property (tbi.roll |=> st_ff.flag)
		else $error("match flag not set at rollover");

	a_flag_clear: assert property (s_flag_clear |=> !st_ff.flag)
		else $error("match flag not cleared by write");

	a_duty_hi_write: assert property (s_duty_hi_write |=>
		st_ff.duty_hi == $past(avs_writedata[7:0]))
		else $error("duty high bits not stored");

	a_duty_lo_write: assert property (s_duty_lo_write |=>
		st_ff.duty_lo == $past(avs_writedata[DCL_LSB+:2]))
		else $error("duty low bits not stored");

	a_dir_write: assert property (s_dir_write |=>
		pwm_pin_oe_n == $past(avs_writedata[DIR_BIT]))
		else $error("pin direction not applied");

	a_active_hold: assert property (!st_ff.active && !tbi.roll |=>
		!st_ff.active)
		else $error("output went active between rollovers");

	a_sleep_pin: assert property (s_sleep_pin |=>
		$stable(pwm_pin_out))
		else $error("pin changed during sleep");

endmodule : tpwm_top
`default_nettype wire

// ==== verification/test_ten_bit_pwm_timer_based.sv ====
// Self-checking bench for the ten-bit pulse-width modulator.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		fail_count++; \
		$display("FAIL %s expected %0h seen %0h", nm, e, g); \
	end \
end
module test_ten_bit_pwm_timer_based
	import tpwm_pkg::*;
;
	logic        clk_sys;
	logic        rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        sleep_req;
	logic        pwm_pin_out;
	logic        pwm_pin_oe_n;
	int          fail_count;
	int          num_checks;
	logic [31:0] q;
	logic [31:0] q1;
	logic        lvl;
	int          hi;
	int          per;
	int          p;
	int          s;
	int          d;
	int          ehi;
	logic [4:0]  ofs [9];
	logic [7:0]  rv  [9];

	tpwm_top uut (
		.clk_sys        (clk_sys),
		.rst            (rst),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (avs_byteenable),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.sleep_req      (sleep_req),
		.pwm_pin_out    (pwm_pin_out),
		.pwm_pin_oe_n   (pwm_pin_oe_n)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic bus(input logic [4:0] a, input logic w,
		input logic [7:0] wd);
		int n;
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= ~w;
		avs_writedata <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			fail_count++;
			end_sim();
		end
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic meas;
		int n;
		n = 0;
		while (pwm_pin_out !== 1'b0 && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		while (pwm_pin_out !== 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		hi = 0;
		while (pwm_pin_out === 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			hi++;
			n++;
		end
		per = hi;
		while (pwm_pin_out !== 1'b1 && n < 5000) begin
			@(posedge clk_sys);
			per++;
			n++;
		end
		if (n >= 5000) begin
			fail_count++;
			end_sim();
		end
	endtask

	function automatic int exp_per(int pl, int sl);
		return (pl + 1) * 4 * (1 << sl);
	endfunction

	function automatic int exp_hi(int dv, int sl);
		return dv * (1 << sl);
	endfunction

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		fail_count = 0;
		num_checks = 0;
		rst = 1'b1;
		sleep_req = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hf;
		ofs = '{CTRL_OFS, DUTY_HI_OFS, DUTY_LO_OFS, PERIOD_OFS, TCTRL_OFS,
			COUNT_OFS, FLAG_OFS, PINDIR_OFS, 5'h1e};
		rv = '{8'h00, 8'h00, 8'h00, PERIOD_RST, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h00};
		void'($urandom(32'he2934dbd));
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		`CHK("pin_oe_n", 1'b1, pwm_pin_oe_n);
		`CHK("pin_out", 1'b0, pwm_pin_out);
		for (int i = 0; i < 9; i++) begin
			bus(ofs[i], 1'b0, 8'h00);
			`CHK("reset value", {24'h000000, rv[i]}, q);
		end
		avs_byteenable <= 4'he;
		bus(PERIOD_OFS, 1'b1, 8'h33);
		avs_byteenable <= 4'hf;
		bus(PERIOD_OFS, 1'b0, 8'h00);
		`CHK("masked write", {24'h000000, PERIOD_RST}, q);
		bus(COUNT_OFS, 1'b1, 8'h55);
		bus(COUNT_OFS, 1'b0, 8'h00);
		`CHK("count", 32'h00000000, q);
		bus(CTRL_OFS, 1'b1, 8'h10);
		repeat (4) @(posedge clk_sys);
		`CHK("idle high", 1'b1, pwm_pin_out);
		bus(CTRL_OFS, 1'b0, 8'h00);
		`CHK("status", 32'h00000030, q);
		bus(PINDIR_OFS, 1'b1, 8'h00);
		`CHK("pin drive", 1'b0, pwm_pin_oe_n);
		for (int t = 0; t < 6; t++) begin
			p = 2 + $urandom % 14;
			s = $urandom % 3;
			d = 1 + $urandom % (4 * (p + 1) - 1);
			if (t == 0)
				d = 1;
			else if (t == 1)
				d = 4 * (p + 1) - 1;
			bus(TCTRL_OFS, 1'b1, 8'h00);
			bus(CTRL_OFS, 1'b1, 8'h00);
			bus(PERIOD_OFS, 1'b1, p[7:0]);
			bus(DUTY_HI_OFS, 1'b1, d[9:2]);
			bus(DUTY_LO_OFS, 1'b1, {d[1:0], 6'h00});
			bus(TCTRL_OFS, 1'b1, {1'b1, s[2:0], 4'h0});
			bus(CTRL_OFS, 1'b1, (t == 2) ? 8'h90 : 8'h80);
			meas();
			meas();
			ehi = (t == 2) ? exp_per(p, s) - exp_hi(d, s) : exp_hi(d, s);
			`CHK("high time", ehi, hi);
			`CHK("period", exp_per(p, s), per);
		end
		bus(FLAG_OFS, 1'b0, 8'h00);
		`CHK("match flag", 32'h00000002, q);
		bus(DUTY_HI_OFS, 1'b1, 8'h00);
		bus(DUTY_LO_OFS, 1'b1, 8'h00);
		repeat (300) @(posedge clk_sys);
		lvl = 1'b0;
		for (int i = 0; i < 300; i++) begin
			@(posedge clk_sys);
			lvl = lvl | pwm_pin_out;
		end
		`CHK("zero duty", 1'b0, lvl);
		bus(DUTY_HI_OFS, 1'b1, 8'h01);
		meas();
		repeat (7) @(posedge clk_sys);
		sleep_req <= 1'b1;
		repeat (6) @(posedge clk_sys);
		lvl = pwm_pin_out;
		bus(COUNT_OFS, 1'b0, 8'h00);
		q1 = q;
		repeat (40) @(posedge clk_sys);
		bus(COUNT_OFS, 1'b0, 8'h00);
		`CHK("sleep count", q1, q);
		`CHK("sleep pin", lvl, pwm_pin_out);
		sleep_req <= 1'b0;
		bus(TCTRL_OFS, 1'b1, 8'h00);
		bus(FLAG_OFS, 1'b1, 8'h02);
		bus(FLAG_OFS, 1'b0, 8'h00);
		`CHK("flag clear", 32'h00000000, q);
		end_sim();
	end
endmodule // test_ten_bit_pwm_timer_based
`default_nettype wire
